// File: rtl/cjs_sequencer.sv
// Conditional jump sequencer for one axis, with AXI4-Lite registers
// Behaviour
// R1 - Jump at once when the selected condition bit is already set.
// R2 - Bit clear: keep destination block and start watching the bit.
// R3 - Bit set while watching jumps; block, jump or call ends watching.
// R4 - Watching starts only when the next motion-class command starts.
// R5 - Dwell, wait, end or reversing move: stop first, then watch.
// R6 - Motion carries through only from continuous move to long enough move.
// R7 - Carried jump uses the destination block's acceleration.
// R8 - Jump stops use jog acceleration and jog acceleration mode.
// R9 - S-curve reaches constant velocity before a jump stop decelerates.
// R10 - Jump during a stop-at-end move always makes a jump stop.
// R11 - Continuous move: jump stop if destination short or reversed.
// R12 - S-curve jump stop after midpoint finishes the change first.
// R13 - S-curve jump stop before midpoint levels acceleration to zero first.
// R14 - Linear or constant-velocity jumps change velocity immediately.
// R15 - S-curve after midpoint: finish change, then destination mode.
// R16 - S-curve before midpoint against trend: level off, then change.
// R17 - Watching persists over further moves until the next block; the code also ends it on a jump or call.
// R18 - While watching, sample the condition bit every 2 ms.
// R19 - Of several jumps with no motion between, only the last counts.
// R20 - A new block after a jump samples the bit one final time.
// R21 - After a jump stop reaches zero, start the destination block.
`timescale 1ns/10ps
module cjs_sequencer #(
  parameter int SAMPLE_CYC = cjs_pkg::SAMPLE_CYC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Condition input bits, asynchronous
  input wire logic [cjs_pkg::NCOND-1:0] condition_input_bit,
  // Profile engine
  input wire cjs_pkg::cjs_prof_s prof_i,
  output cjs_pkg::cjs_mot_s mot_o
);

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [cjs_pkg::NCOND-1:0] sync1;
    logic [cjs_pkg::NCOND-1:0] sync2;
    cjs_pkg::cjs_st_e st;
    logic [7:0] dest;
    logic [3:0] sel;
    logic cur_pm;
    logic cur_dir;
    logic moving;
    logic [2:0] dinfo;
    logic [15:0] tmr;
    cjs_pkg::cjs_mot_s mot;
  } cjs_state_s;

  cjs_state_s s_q;
  cjs_state_s s_d;
  logic cbit;
  logic cmd_go;
  logic wr_go;
  logic trig;
  logic stop_need;
  logic cont;
  logic is_move;
  cjs_pkg::cjs_op_e cmd_op;
  logic [7:0] cmd_blk;
  logic cmd_dir;
  logic busy;

  assign cmd_op = cjs_pkg::cjs_op_e'(s_q.wdata[cjs_pkg::CMD_OP_LSB +: 3]);
  assign cmd_blk = s_q.wdata[cjs_pkg::CMD_BLK_LSB +: 8];
  assign cmd_dir = s_q.wdata[cjs_pkg::CMD_DIR_BIT];
  assign is_move = (cmd_op == cjs_pkg::OP_CONTINUOUS_MOVE) ||
                   (cmd_op == cjs_pkg::OP_STOP_AT_END_MOVE);
  assign busy = (s_q.st == cjs_pkg::ST_NSTOP) ||
                (s_q.st == cjs_pkg::ST_JPREP) ||
                (s_q.st == cjs_pkg::ST_JSTOP);
  // Only the second sync stage is ever looked at
  assign cbit = s_q.sync2[s_q.sel];
  assign stop_need = !is_move ||
                     (s_q.moving && (cmd_dir != s_q.cur_dir));

  always_comb begin
    s_d = s_q;
    s_d.mot.jump = 1'b0;
    s_d.mot.start_dest = 1'b0;
    s_d.sync1 = condition_input_bit;
    s_d.sync2 = s_q.sync1;
    wr_go = 1'b0;
    cmd_go = 1'b0;
    trig = 1'b0;
    cont = 1'b0;
    // Write channels, taken in either order
    if (awvalid && s_q.awrdy) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
      s_d.awrdy = 1'b0;
    end
    if (wvalid && s_q.wrdy) begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
      s_d.wrdy = 1'b0;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
      s_d.awrdy = 1'b1;
      s_d.wrdy = 1'b1;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = cjs_pkg::RESP_SLVERR;
      // Partial writes would split a command word, so refuse them
      wr_go = (s_q.wstrb == 4'hf);
      if (wr_go) begin
        case (s_q.awaddr)
          cjs_pkg::CMD_OFS: begin
            if (!busy) begin
              cmd_go = 1'b1;
              s_d.bresp = cjs_pkg::RESP_OKAY;
            end
          end
          cjs_pkg::DEST_OFS: begin
            s_d.dinfo = s_q.wdata[2:0];
            s_d.bresp = cjs_pkg::RESP_OKAY;
          end
          cjs_pkg::JOG_OFS: begin
            s_d.mot.jog_mode = s_q.wdata[0];
            s_d.bresp = cjs_pkg::RESP_OKAY;
          end
          default: begin
            s_d.bresp = cjs_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // Read channel
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
      s_d.arrdy = 1'b1;
    end
    if (arvalid && s_q.arrdy) begin
      s_d.arrdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.rresp = cjs_pkg::RESP_OKAY;
      case (araddr)
        cjs_pkg::DEST_OFS: s_d.rdata[2:0] = s_q.dinfo;
        cjs_pkg::JOG_OFS: s_d.rdata[0] = s_q.mot.jog_mode;
        cjs_pkg::STAT_OFS: begin
          s_d.rdata[cjs_pkg::STAT_ST_LSB +: 3] = s_q.st;
          s_d.rdata[cjs_pkg::STAT_TEST_BIT] = s_q.mot.testing;
          s_d.rdata[cjs_pkg::STAT_BLK_LSB +: 8] = s_q.mot.block;
          s_d.rdata[cjs_pkg::STAT_DEST_LSB +: 8] = s_q.dest;
          s_d.rdata[cjs_pkg::STAT_SEL_LSB +: 4] = s_q.sel;
        end
        cjs_pkg::CMD_OFS: s_d.rdata = 32'h0000_0000;
        default: s_d.rresp = cjs_pkg::RESP_SLVERR;
      endcase
    end
    // Periodic sample while watching
    if (s_q.st == cjs_pkg::ST_TEST) begin
      if (s_q.tmr == 16'(SAMPLE_CYC - 1)) begin
        s_d.tmr = 16'h0000;
        trig = cbit; // [R18] [R3]
      end else begin
        s_d.tmr = s_q.tmr + 16'h0001;
      end
    end
    case (s_q.st)
      cjs_pkg::ST_IDLE, cjs_pkg::ST_ARMED, cjs_pkg::ST_TEST: begin
        if (cmd_go) begin
          case (cmd_op)
            cjs_pkg::OP_BLOCK: begin
              // Last look at the bit as the block changes
              if (s_q.st != cjs_pkg::ST_IDLE && cbit) begin
                trig = 1'b1; // [R20]
              end else begin
                trig = 1'b0;
                s_d.mot.block = cmd_blk;
                s_d.st = cjs_pkg::ST_IDLE; // [R3]
              end
            end
            cjs_pkg::OP_JUMP: begin
              // A later jump simply overwrites an armed one
              trig = 1'b0;
              s_d.st = cjs_pkg::ST_ARMED; // [R2] [R19] [R3]
              s_d.dest = cmd_blk;
              s_d.sel = s_q.wdata[cjs_pkg::CMD_SEL_LSB +: 4];
            end
            cjs_pkg::OP_CALL: begin
              trig = 1'b0;
              s_d.st = cjs_pkg::ST_IDLE; // [R3]
            end
            default: begin
              s_d.mot.dest_accel = 1'b0;
              s_d.moving = is_move;
              s_d.cur_pm = (cmd_op == cjs_pkg::OP_STOP_AT_END_MOVE);
              s_d.cur_dir = is_move ? cmd_dir : s_q.cur_dir;
              if (s_q.st == cjs_pkg::ST_ARMED) begin
                s_d.tmr = 16'h0000;
                if (stop_need) begin
                  s_d.st = cjs_pkg::ST_NSTOP; // [R4] [R5]
                  s_d.mot.stop = 1'b1;
                end else begin
                  s_d.st = cjs_pkg::ST_TEST; // [R4] [R2]
                  trig = cbit; // [R1]
                end
              end
              // In ST_TEST further moves keep watching [R17]
            end
          endcase
        end
      end
      cjs_pkg::ST_NSTOP: begin
        if (prof_i.zero_vel) begin
          s_d.mot.stop = 1'b0;
          s_d.moving = 1'b0;
          s_d.st = cjs_pkg::ST_TEST;
          s_d.tmr = 16'h0000;
          trig = cbit; // [R5]
        end
      end
      cjs_pkg::ST_JPREP: begin
        // Hold off until the s-curve has levelled out
        if (!prof_i.scurve || prof_i.const_vel) begin // [R9]
          s_d.st = cjs_pkg::ST_JSTOP;
          s_d.mot.stop = 1'b1;
          s_d.mot.jog_accel = 1'b1; // [R8]
          s_d.mot.shape = cjs_pkg::SH_NOW;
        end
      end
      cjs_pkg::ST_JSTOP: begin
        if (prof_i.zero_vel) begin
          s_d.st = cjs_pkg::ST_IDLE;
          s_d.mot.stop = 1'b0;
          s_d.mot.jog_accel = 1'b0;
          s_d.moving = 1'b0;
          s_d.mot.block = s_q.dest;
          s_d.mot.start_dest = 1'b1; // [R21]
        end
      end
      default: begin
        s_d.st = cjs_pkg::ST_IDLE;
      end
    endcase
    // Jump taken: carry motion through or stop on it
    if (trig) begin
      s_d.mot.jump = 1'b1;
      // Next-state view, so a move decoded this cycle is the one judged
      cont = !s_d.cur_pm && s_d.moving &&
             s_q.dinfo[cjs_pkg::DEST_MOVE_BIT] &&
             s_q.dinfo[cjs_pkg::DEST_FAR_BIT] &&
             (s_q.dinfo[cjs_pkg::DEST_DIR_BIT] == s_d.cur_dir); // [R6] [R11]
      if (!prof_i.scurve || prof_i.const_vel) begin
        s_d.mot.shape = cjs_pkg::SH_NOW; // [R14]
      end else if (prof_i.past_mid) begin
        s_d.mot.shape = cjs_pkg::SH_FINISH; // [R12] [R15]
      end else if (cont && prof_i.accel_up == prof_i.dest_higher) begin
        s_d.mot.shape = cjs_pkg::SH_HOLD;
      end else begin
        s_d.mot.shape = cjs_pkg::SH_LEVEL; // [R13] [R16]
      end
      if (cont) begin
        s_d.st = cjs_pkg::ST_IDLE;
        s_d.mot.block = s_q.dest;
        s_d.mot.dest_accel = 1'b1; // [R7]
        s_d.mot.start_dest = 1'b1;
      end else begin
        s_d.st = cjs_pkg::ST_JPREP; // [R10] [R11]
        s_d.mot.stop = 1'b0;
      end
    end
    s_d.mot.testing = (s_d.st == cjs_pkg::ST_TEST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
      s_q.dinfo <= cjs_pkg::DEST_RST;
      s_q.mot.block <= cjs_pkg::BLK_RST;
      s_q.mot.jog_mode <= cjs_pkg::JOG_MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arrdy;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign mot_o = s_q.mot;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_arm_keeps_dest: assert property ( // [R2]
    cmd_go && cmd_op == cjs_pkg::OP_JUMP |=>
      s_q.st == cjs_pkg::ST_ARMED && s_q.dest == $past(cmd_blk))
    else $error("jump not armed with its destination");
  a_set_bit_jumps: assert property ( // [R1]
    cmd_go && s_q.st == cjs_pkg::ST_ARMED && is_move && !stop_need &&
      cbit |=> s_q.mot.jump)
    else $error("set condition bit did not jump at once");
  a_call_ends_test: assert property ( // [R3]
    cmd_go && cmd_op == cjs_pkg::OP_CALL |=>
      !s_q.mot.testing && s_q.st == cjs_pkg::ST_IDLE)
    else $error("call did not end watching");
  a_dwell_stops: assert property ( // [R5]
    cmd_go && s_q.st == cjs_pkg::ST_ARMED &&
      cmd_op == cjs_pkg::OP_DWELL |=>
      s_q.st == cjs_pkg::ST_NSTOP && s_q.mot.stop && !s_q.mot.jump)
    else $error("no normal stop before watching");
  a_sample_tick: assert property ( // [R18]
    s_q.st == cjs_pkg::ST_TEST && !cmd_go && cbit &&
      s_q.tmr == 16'(SAMPLE_CYC - 1) |=> s_q.mot.jump)
    else $error("periodic sample missed the set bit");
  a_sample_bound: assert property ( // [R18]
    s_q.st == cjs_pkg::ST_TEST |-> s_q.tmr < 16'(SAMPLE_CYC))
    else $error("sample timer ran past its period");
  a_block_final: assert property ( // [R20]
    cmd_go && cmd_op == cjs_pkg::OP_BLOCK &&
      s_q.st == cjs_pkg::ST_TEST && cbit |=> s_q.mot.jump)
    else $error("new block skipped the final sample");
  a_stop_at_end_move_jstop: assert property ( // [R10]
    s_q.mot.jump && s_q.cur_pm |-> s_q.st == cjs_pkg::ST_JPREP)
    else $error("jump in stop-at-end move did not jump stop");
  a_carry_accel: assert property ( // [R7]
    s_q.mot.jump && s_q.st == cjs_pkg::ST_IDLE |->
      s_q.mot.dest_accel && s_q.mot.start_dest && !s_q.mot.stop)
    else $error("carried jump lacks destination acceleration");
  a_scurve_wait: assert property ( // [R9]
    s_q.st == cjs_pkg::ST_JPREP && prof_i.scurve && !prof_i.const_vel
      |=> s_q.st == cjs_pkg::ST_JPREP && !s_q.mot.stop)
    else $error("jump stop began before constant velocity");
  a_jog_used: assert property ( // [R8]
    s_q.st == cjs_pkg::ST_JSTOP |-> s_q.mot.jog_accel && s_q.mot.stop)
    else $error("jump stop without jog acceleration");
  a_dest_start: assert property ( // [R21]
    s_q.st == cjs_pkg::ST_JSTOP && prof_i.zero_vel |=>
      s_q.mot.start_dest && s_q.mot.block == $past(s_q.dest))
    else $error("destination not started after jump stop");
  a_bvalid_hold: assert property (
    s_q.bvalid && !bready |=> s_q.bvalid)
    else $error("write response dropped early");

  c_carry: cover property (s_q.mot.jump && s_q.st == cjs_pkg::ST_IDLE);
  c_jstop: cover property (s_q.st == cjs_pkg::ST_JSTOP ##1
    s_q.mot.start_dest);
  c_nstop: cover property (s_q.st == cjs_pkg::ST_NSTOP ##1
    s_q.st == cjs_pkg::ST_TEST);
  c_level: cover property (s_q.mot.jump &&
    s_q.mot.shape == cjs_pkg::SH_LEVEL);

endmodule : cjs_sequencer

// File: rtl/cjs_pkg.sv
// Constants and types for the conditional jump sequencer
package cjs_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] DEST_OFS = 8'h04;
  localparam logic [7:0] JOG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_BLK_LSB = 8;
  localparam int CMD_DIR_BIT = 16;
  // Destination info fields
  localparam int DEST_DIR_BIT = 0;
  localparam int DEST_FAR_BIT = 1;
  localparam int DEST_MOVE_BIT = 2;
  // Status fields
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_TEST_BIT = 3;
  localparam int STAT_BLK_LSB = 8;
  localparam int STAT_DEST_LSB = 16;
  localparam int STAT_SEL_LSB = 24;
  // Reset values
  localparam logic [7:0] BLK_RST = 8'h00;
  localparam logic [2:0] DEST_RST = 3'h0;
  localparam logic JOG_MODE_RST = 1'b0;
  // Condition sampling period
  localparam int SAMPLE_US = 2000;
  localparam int CLK_KHZ = 25000;
  localparam int SAMPLE_CYC_DEF = SAMPLE_US * CLK_KHZ / 1000;
  localparam int NCOND = 16;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_BLOCK = 3'b000,
    OP_JUMP = 3'b001,
    OP_CALL = 3'b010,
    OP_CONTINUOUS_MOVE = 3'b011,
    OP_STOP_AT_END_MOVE = 3'b100,
    OP_DWELL = 3'b101,
    OP_WAIT = 3'b110,
    OP_END = 3'b111
  } cjs_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_TEST = 3'b010,
    ST_NSTOP = 3'b011,
    ST_JPREP = 3'b100,
    ST_JSTOP = 3'b101
  } cjs_st_e;

  typedef enum logic [1:0] {
    SH_NOW = 2'b00,
    SH_FINISH = 2'b01,
    SH_LEVEL = 2'b10,
    SH_HOLD = 2'b11
  } cjs_shape_e;

  // Profile engine status, same clock
  typedef struct packed {
    logic scurve;
    logic const_vel;
    logic past_mid;
    logic zero_vel;
    logic accel_up;
    logic dest_higher;
  } cjs_prof_s;

  // Requests to the profile engine
  typedef struct packed {
    logic jump;
    logic start_dest;
    logic stop;
    logic jog_accel;
    logic jog_mode;
    logic dest_accel;
    logic testing;
    cjs_shape_e shape;
    logic [7:0] block;
  } cjs_mot_s;
endpackage : cjs_pkg

// File: tb/cjs_prof_model.sv
// Behavioural profile engine facing the sequencer
`timescale 1ns/10ps
module cjs_prof_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic go,
  input wire logic scurve,
  input wire logic [2:0] phase,
  input wire logic [7:0] dly,
  // Sequencer side
  input wire cjs_pkg::cjs_mot_s mot,
  output cjs_pkg::cjs_prof_s prof
);
  logic moving_q;
  logic flat_q;
  logic [7:0] lvl_q;
  logic [7:0] dec_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      moving_q <= 1'b0;
      flat_q <= 1'b1;
      lvl_q <= 8'h00;
      dec_q <= 8'h00;
    end else begin
      if (go) begin
        moving_q <= 1'b1;
        flat_q <= !scurve;
      end
      // Change in progress settles dly cycles after a jump
      // A new move drops any change still settling from the last jump
      if (mot.jump) lvl_q <= dly;
      else if (go) lvl_q <= 8'h00;
      else if (lvl_q != 8'h00) lvl_q <= lvl_q - 8'h01;
      if (lvl_q == 8'h01 && !go) flat_q <= 1'b1;
      // Brakes only once flat, so an early stop is held until flat_q sets
      if (!(mot.stop && flat_q)) dec_q <= dly;
      else if (dec_q != 8'h00) dec_q <= dec_q - 8'h01;
      if (dec_q == 8'h01) moving_q <= 1'b0;
    end
  end

  assign prof = {scurve, flat_q, phase[2], !moving_q, phase[1:0]};
endmodule : cjs_prof_model

// File: tb/tb_top.sv
// Self-checking bench for the conditional jump sequencer
`timescale 1ns/10ps
module tb_top;
  localparam int SC = 64;
  localparam logic [31:0] M_ST = 32'h0000ff0f;
  localparam logic [31:0] M_ALL = 32'h0fffff0f;
  localparam logic [9:0] TAB [12] = '{10'h180, 10'h181, 10'h182, 10'h381,
    10'h1c1, 10'h101, 10'h3b0, 10'h3a1, 10'h1b0, 10'h1a8, 10'h1ac, 10'h3a2};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, scurve = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] cond = 16'h0000;
  logic [2:0] phase = 3'h0;
  logic [7:0] dly = 8'h04;
  cjs_pkg::cjs_prof_s prof;
  cjs_pkg::cjs_mot_s mot;
  cjs_pkg::cjs_shape_e shp;
  int n_errors = 0, checks_done = 0, seed = 14;
  int n_jump = 0, n_start = 0, n_js = 0, n_early = 0;

  always #20 aclk = ~aclk;

  cjs_sequencer #(.SAMPLE_CYC(SC)) u_cjs_sequencer (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .condition_input_bit(cond), .prof_i(prof), .mot_o(mot));
  cjs_prof_model u_cjs_prof_model (.aclk(aclk), .aresetn(aresetn), .go(go),
    .scurve(scurve), .phase(phase), .dly(dly), .mot(mot), .prof(prof));

  // Pulses last one cycle, so they are counted here
  always @(posedge aclk) begin
    if (mot.jump === 1'b1) n_jump <= n_jump + 1;
    if (mot.jump === 1'b1) shp <= mot.shape;
    if (mot.start_dest === 1'b1) n_start <= n_start + 1;
    if ((mot.stop & mot.jog_accel) === 1'b1) n_js <= n_js + 1;
    if ((mot.stop & mot.jog_accel & scurve & !prof.const_vel) === 1'b1)
      n_early <= n_early + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk("rdata", exp & m, rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // Moves also start the partner's motion one cycle ahead
  task automatic cmd(input cjs_pkg::cjs_op_e op, input logic [3:0] s,
                     input logic [7:0] b);
    go <= (op == cjs_pkg::OP_CONTINUOUS_MOVE || op == cjs_pkg::OP_STOP_AT_END_MOVE);
    @(posedge aclk);
    go <= 1'b0;
    wr(cjs_pkg::CMD_OFS, {16'h0, b, s, 1'b0, op}, 4'hf, cjs_pkg::RESP_OKAY);
  endtask : cmd

  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 400 && n_start < n; k++) @(posedge aclk);
    chk("start_dest", n, n_start);
  endtask : wait_n

  function automatic logic [31:0] stat(input logic [2:0] st,
    input logic [7:0] b, input logic [7:0] d, input logic [3:0] s);
    return {4'h0, s, d, b, 4'h0, st == 3'h2, st};
  endfunction : stat

  function automatic cjs_pkg::cjs_shape_e eshape(input logic sc,
    input logic [2:0] ph, input logic js);
    if (!sc) return cjs_pkg::SH_NOW;
    if (ph[2]) return cjs_pkg::SH_FINISH;
    if (js || ph[1] != ph[0]) return cjs_pkg::SH_LEVEL;
    return cjs_pkg::SH_HOLD;
  endfunction : eshape

  // t: stop_at_end_move, dest info, scurve, past_mid, accel_up, dest_higher, trigger
  task automatic jt(input logic [9:0] t);
    logic [3:0] s;
    logic [7:0] b, d;
    logic js;
    int j0, s0, q0;
    cjs_pkg::cjs_op_e mv;
    cjs_pkg::cjs_shape_e e;
    s = 4'($random(seed));
    b = 8'($random(seed));
    d = 8'($random(seed));
    mv = t[9] ? cjs_pkg::OP_STOP_AT_END_MOVE : cjs_pkg::OP_CONTINUOUS_MOVE;
    js = t[9] | (t[8:6] != 3'b110);
    e = eshape(t[5], t[4:2], js);
    j0 = n_jump;
    s0 = n_start;
    q0 = n_js;
    scurve <= t[5];
    phase <= t[4:2];
    dly <= 8'h02 + 8'($random(seed) & 31);
    cond <= (16'($random(seed)) & ~(16'h1 << s)) | (16'(t[1:0] == 0) << s);
    wr(cjs_pkg::DEST_OFS, {29'h0, t[8:6]}, 4'hf, cjs_pkg::RESP_OKAY);
    cmd(cjs_pkg::OP_BLOCK, 4'h0, b);
    cmd(cjs_pkg::OP_JUMP, s, d);
    rd(cjs_pkg::STAT_OFS, stat(3'h1, b, d, s), M_ST, 2'h0);
    chk("jumps", j0, n_jump);
    cmd(mv, 4'h0, 8'h00);
    if (t[1:0] == 2'h0) begin
      @(posedge aclk);
      chk("jumps", j0 + 1, n_jump);
    end else begin
      rd(cjs_pkg::STAT_OFS, stat(3'h2, b, d, s), M_ALL, 2'h0);
      chk("testing", 32'h1, 32'(mot.testing));
      cmd(mv, 4'h0, 8'h00);
      rd(cjs_pkg::STAT_OFS, stat(3'h2, b, d, s), M_ALL, 2'h0);
      cond[s] <= 1'b1;
      if (t[1]) begin
        repeat (3) @(posedge aclk);
        cmd(cjs_pkg::OP_BLOCK, 4'h0, b + 8'h01);
      end
    end
    wait_n(s0 + 1);
    chk("jumps", j0 + 1, n_jump);
    chk("shape", 32'(e), 32'(shp));
    chk("jump stop", 32'(js), 32'(n_js != q0));
    chk("block", {24'h0, d}, {24'h0, mot.block});
    chk("dest accel", 32'(!js), 32'(mot.dest_accel));
    $display("jump case %h done", t);
  endtask : jt

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  initial begin
    int i;
    logic [31:0] v;
    logic [3:0] s;
    logic [7:0] b, d;
    int j0, s0;
    repeat (6) @(posedge aclk);
    chk("reset outputs", 32'h0, 32'(mot));
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, 32'hffffffff, 2'h0);
    rd(8'h10, 32'h0, 32'hffffffff, cjs_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1, 4'hf, cjs_pkg::RESP_SLVERR);
    wr(cjs_pkg::JOG_OFS, 32'h1, 4'h3, cjs_pkg::RESP_SLVERR);
    rd(cjs_pkg::JOG_OFS, 32'h0, 32'h1, 2'h0);
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(cjs_pkg::JOG_OFS, v, 4'hf, cjs_pkg::RESP_OKAY);
      rd(cjs_pkg::JOG_OFS, v, 32'h1, 2'h0);
      chk("jog mode", 32'(v[0]), 32'(mot.jog_mode));
      wr(cjs_pkg::DEST_OFS, v, 4'hf, cjs_pkg::RESP_OKAY);
      rd(cjs_pkg::DEST_OFS, v, 32'h7, 2'h0);
    end
    $display("register test done");
    for (i = 0; i < 24; i++) begin
      v = $random(seed);
      jt(i < 12 ? TAB[i] : v[9:0]);
    end
    s = 4'($random(seed));
    b = 8'($random(seed));
    d = 8'($random(seed));
    for (i = 0; i < 2; i++) begin
      j0 = n_jump;
      cond <= 16'h0000;
      cmd(cjs_pkg::OP_BLOCK, 4'h0, b);
      cmd(cjs_pkg::OP_JUMP, s, d);
      cmd(cjs_pkg::OP_CONTINUOUS_MOVE, 4'h0, 8'h00);
      cmd(i != 0 ? cjs_pkg::OP_CALL : cjs_pkg::OP_BLOCK, 4'h0, d);
      rd(cjs_pkg::STAT_OFS, stat(3'h0, i != 0 ? b : d, 8'h0, 4'h0), M_ST,
         2'h0);
      cond <= 16'hffff;
      repeat (SC + 8) @(posedge aclk);
      chk("jumps", j0, n_jump);
    end
    $display("watch end test done");
    j0 = n_jump;
    s0 = n_start;
    scurve <= 1'b0;
    dly <= 8'h30;
    wr(cjs_pkg::DEST_OFS, 32'h6, 4'hf, cjs_pkg::RESP_OKAY);
    cmd(cjs_pkg::OP_BLOCK, 4'h0, b);
    cmd(cjs_pkg::OP_CONTINUOUS_MOVE, 4'h0, 8'h00);
    cmd(cjs_pkg::OP_JUMP, s, ~d);
    cmd(cjs_pkg::OP_JUMP, s + 4'h1, d);
    cmd(cjs_pkg::OP_DWELL, 4'h0, 8'h00);
    rd(cjs_pkg::STAT_OFS, stat(3'h3, b, d, s), M_ST, 2'h0);
    chk("jumps", j0, n_jump);
    wait_n(s0 + 1);
    chk("block", {24'h0, d}, {24'h0, mot.block});
    chk("early brake", 32'h0, n_early);
    $display("dwell stop test done");
    test_done();
  end

  // A hang is cut short well beyond the expected run length
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule : tb_top
